// file: src/cst_pkg.sv
// Package for the clock source start-up sequencer: register map, fuse encodings,
// delay counts and shared types.
// Assumes a single 200 MHz core clock and an AXI4-Lite register master.
package cst_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] ADDR_TRIM   = 8'h00; // Oscillator trim register.
    localparam logic [7:0] ADDR_CONFIG = 8'h04; // Fuse image and wake request.
    localparam logic [7:0] ADDR_STATUS = 8'h08; // Sequencer status.

    // Field positions inside the configuration register.
    localparam int CFG_SEL_LSB  = 0;  // Four source-select fuse bits.
    localparam int CFG_SUT_LSB  = 4;  // Two start-up time fuse bits.
    localparam int CFG_DIV8_BIT = 6;  // Divide-by-eight fuse.
    localparam int CFG_RDIS_BIT = 7;  // Reset-pin-disable fuse.
    localparam int CFG_WAKE_BIT = 8;  // Write one to request a wake-up.

    // Reset image of the fuses: internal RC, longest start-up, divide by eight,
    // reset pin left enabled (its disable fuse reads one, unprogrammed).
    localparam logic [7:0] FUSE_RESET = 8'hA2;

    // Source-select encodings.
    localparam logic [3:0] SEL_RC      = 4'h2;
    localparam logic [3:0] SEL_LF_FAST = 4'h6;
    localparam logic [3:0] SEL_LF_SLOW = 4'h7;

    // Start-up delay counts in selected-clock cycles.
    localparam logic [15:0] CK_6    = 16'h0006;
    localparam logic [15:0] CK_14   = 16'h000E;
    localparam logic [15:0] CK_258  = 16'h0102;
    localparam logic [15:0] CK_1K   = 16'h0400;
    localparam logic [15:0] CK_16K  = 16'h4000;
    localparam logic [15:0] CK_32K  = 16'h8000;

    // Watchdog oscillator counts for the long reset delays.
    localparam logic [16:0] WDT_NONE = 17'h00000;
    localparam logic [16:0] WDT_4K   = 17'h01000;
    localparam logic [16:0] WDT_64K  = 17'h10000;

    // Clock division.
    localparam logic [2:0] DIV8_LAST = 3'h7;

    // Source classes decoded from the fuses.
    typedef enum logic [1:0] {
        SRC_XTAL = 2'b00,
        SRC_LF   = 2'b01,
        SRC_RC   = 2'b10,
        SRC_NONE = 2'b11
    } cst_src_t;

    // Decoded start-up requirement.
    typedef struct packed {
        logic [15:0] clk_cycles;
        logic [16:0] wdt_cycles;
    } cst_delay_t;

endpackage : cst_pkg

// file: src/cst_sequencer.sv
// Clock source start-up sequencer with the oscillator trim register behind an
// AXI4-Lite slave.
// Assumes pulse inputs from the oscillator models are asynchronous and are
// synchronised here; one core clock CORE_CLK.
// The fuse image is a register here, loaded at reset and rewritten by software.
// Function
// - Upper select bits choose crystal frequency range.
// - Crystal wake delay from low bit and SUT.
// - Crystal reset delay cycles 14, +4.1ms, +65ms.
// - Select 0110/0111 picks low-frequency crystal.
// - Low-frequency reset delay follows SUT fuses.
// - Low-frequency wake delay 1K or 32K.
// - Select 0010 picks internal RC oscillator.
// - Reset loads calibration byte into trim.
// - RC wake 6 cycles; reset delay by SUT.
// - Reset-pin-disable stretches RC SUT00 to 4.1ms.
// - Watchdog oscillator times the reset delay.
// - Trim register 8-bit read-write, retunes RC.
// - Divide-by-eight fuse divides internal clock.
// - Fuse bit zero means programmed.
// - 4.1ms is 4096, 65ms 65536 watchdog cycles.
`timescale 1ns/10ps
`default_nettype none

module cst_sequencer #(
    parameter logic [7:0] CAL_BYTE = 8'h80 // Factory calibration value, arbitrary default.
) (
    // Clock and reset.
    input  wire  logic        CORE_CLK,
    input  wire  logic        RSTN,
    // Oscillator ticks from the selected source and the watchdog oscillator.
    input  wire  logic        SRC_TICK,
    input  wire  logic        WDT_TICK,
    // AXI4-Lite write address and data.
    input  wire  logic [7:0]  S_AXI_AWADDR,
    input  wire  logic        S_AXI_AWVALID,
    output var   logic        S_AXI_AWREADY,
    input  wire  logic [31:0] S_AXI_WDATA,
    input  wire  logic [3:0]  S_AXI_WSTRB,
    input  wire  logic        S_AXI_WVALID,
    output var   logic        S_AXI_WREADY,
    // AXI4-Lite write response.
    output var   logic [1:0]  S_AXI_BRESP,
    output var   logic        S_AXI_BVALID,
    input  wire  logic        S_AXI_BREADY,
    // AXI4-Lite read channels.
    input  wire  logic [7:0]  S_AXI_ARADDR,
    input  wire  logic        S_AXI_ARVALID,
    output var   logic        S_AXI_ARREADY,
    output var   logic [31:0] S_AXI_RDATA,
    output var   logic [1:0]  S_AXI_RRESP,
    output var   logic        S_AXI_RVALID,
    input  wire  logic        S_AXI_RREADY,
    // Results toward the core.
    output var   logic        CORE_RUN,
    output var   logic        CORE_CLK_EN,
    output var   logic [7:0]  OSC_TRIM,
    output var   logic [1:0]  OSC_RANGE,
    output var   logic [1:0]  CLK_SOURCE
);

    // Sequencer states.
    typedef enum logic [1:0] {
        ST_CLK  = 2'b00,
        ST_WDT  = 2'b01,
        ST_RUN  = 2'b10
    } cst_state_t;

    // Two-flop synchronisers and edge history for the oscillator ticks.
    // The edge history reads only the second stage, so a metastable first stage is never used.
    logic [1:0] src_sync;
    logic [1:0] wdt_sync;
    logic       src_last;
    logic       wdt_last;
    wire  logic src_edge = src_sync[1] & ~src_last;
    wire  logic wdt_edge = wdt_sync[1] & ~wdt_last;

    // Register contents.
    logic [7:0]  trim;     // Oscillator trim value.
    logic [7:0]  fuses;    // Fuse image, one means unprogrammed.
    cst_state_t  state;    // Sequencer state.
    logic [15:0] clk_cnt;  // Selected-clock cycle counter.
    logic [16:0] wdt_cnt;  // Watchdog cycle counter.
    logic [2:0]  div_cnt;  // Divide-by-eight counter.
    logic        from_reset; // Current start-up came from reset.

    // Fuse fields.
    wire logic [3:0] sel  = fuses[cst_pkg::CFG_SEL_LSB +: 4];
    wire logic [1:0] sut  = fuses[cst_pkg::CFG_SUT_LSB +: 2];
    wire logic       div8 = ~fuses[cst_pkg::CFG_DIV8_BIT];
    wire logic       rdis = ~fuses[cst_pkg::CFG_RDIS_BIT];

    // Classifies the source-select fuses.
    // Reserved select codes fall into the none class and use the RC timing without the reset-pin-disable stretch.
    function automatic cst_pkg::cst_src_t classify(input logic [3:0] s);
        if (s[3]) begin
            classify = cst_pkg::SRC_XTAL;
        end else if (s == cst_pkg::SEL_LF_FAST || s == cst_pkg::SEL_LF_SLOW) begin
            classify = cst_pkg::SRC_LF;
        end else if (s == cst_pkg::SEL_RC) begin
            classify = cst_pkg::SRC_RC;
        end else begin
            classify = cst_pkg::SRC_NONE;
        end
    endfunction : classify

    // Maps a three-way reset option to watchdog cycles.
    // The reserved setting takes the longest delay rather than none.
    function automatic logic [16:0] reset_wdt(input logic [1:0] opt);
        case (opt)
            2'b00:   reset_wdt = cst_pkg::WDT_NONE;
            2'b01:   reset_wdt = cst_pkg::WDT_4K;
            default: reset_wdt = cst_pkg::WDT_64K;
        endcase
    endfunction : reset_wdt

    // Computes the start-up requirement for the current fuses.
    function automatic cst_pkg::cst_delay_t decode(input logic [3:0] s, input logic [1:0] u,
                                                    input logic rd, input logic rst);
        cst_pkg::cst_delay_t d;
        logic [2:0] combo;
        d = '0;
        combo = {s[0], u};
        case (classify(s))
            cst_pkg::SRC_XTAL: begin
                if (!s[0] && !u[1]) begin
                    d.clk_cycles = cst_pkg::CK_258;
                end else if (!s[0] || u == 2'b00) begin
                    d.clk_cycles = cst_pkg::CK_1K;
                end else begin
                    d.clk_cycles = cst_pkg::CK_16K;
                end
                // Combination 0/00 starts at 4.1 ms; the cycle repeats every three.
                case (combo)
                    3'd0, 3'd3, 3'd6: d.wdt_cycles = cst_pkg::WDT_4K;
                    3'd1, 3'd4, 3'd7: d.wdt_cycles = cst_pkg::WDT_64K;
                    default:          d.wdt_cycles = cst_pkg::WDT_NONE;
                endcase
            end
            cst_pkg::SRC_LF: begin
                d.clk_cycles = s[0] ? cst_pkg::CK_32K : cst_pkg::CK_1K;
                d.wdt_cycles = reset_wdt(u);
            end
            cst_pkg::SRC_RC: begin
                d.clk_cycles = cst_pkg::CK_6;
                d.wdt_cycles = (rd && u == 2'b00) ? cst_pkg::WDT_4K : reset_wdt(u);
            end
            default: begin
                d.clk_cycles = cst_pkg::CK_6;
                d.wdt_cycles = reset_wdt(u);
            end
        endcase
        // From reset the source delay is the fixed 14 cycles plus the watchdog part.
        if (rst) begin
            d.clk_cycles = cst_pkg::CK_14;
        end else begin
            d.wdt_cycles = cst_pkg::WDT_NONE;
        end
        decode = d;
    endfunction : decode

    // The requirement follows the fuse image live, so a fuse write during start-up
    // retargets the running count; software normally changes fuses only while running.
    wire cst_pkg::cst_delay_t need = decode(sel, sut, rdis, from_reset);

    // AXI handshake bookkeeping. A write needs address and data together and no pending
    // response, so one write and one read at most are ever in flight.
    wire logic wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
    wire logic rd_go = S_AXI_ARVALID & ~S_AXI_RVALID;
    wire logic wr_trim = wr_go & (S_AXI_AWADDR == cst_pkg::ADDR_TRIM) & S_AXI_WSTRB[0];
    wire logic wr_cfg  = wr_go & (S_AXI_AWADDR == cst_pkg::ADDR_CONFIG);
    wire logic wr_ok   = (S_AXI_AWADDR == cst_pkg::ADDR_TRIM) | (S_AXI_AWADDR == cst_pkg::ADDR_CONFIG);
    wire logic wake    = wr_cfg & S_AXI_WSTRB[1] & S_AXI_WDATA[cst_pkg::CFG_WAKE_BIT];
    wire logic [31:0] rd_val =
        (S_AXI_ARADDR == cst_pkg::ADDR_TRIM)   ? {24'h000000, trim} :
        (S_AXI_ARADDR == cst_pkg::ADDR_CONFIG) ? {24'h000000, fuses} :
        {28'h0000000, state == ST_RUN, from_reset, classify(sel)};
    wire logic rd_ok = (S_AXI_ARADDR == cst_pkg::ADDR_TRIM) | (S_AXI_ARADDR == cst_pkg::ADDR_CONFIG) |
                       (S_AXI_ARADDR == cst_pkg::ADDR_STATUS);

    // Synchronises the asynchronous oscillator ticks.
    always_ff @(posedge CORE_CLK) begin
        src_sync <= {src_sync[0], SRC_TICK};
        wdt_sync <= {wdt_sync[0], WDT_TICK};
        src_last <= src_sync[1];
        wdt_last <= wdt_sync[1];
    end

    // AXI slave: single-cycle accept, response held until taken.
    // The ready pulse lasts one cycle; the response valid rises on the cycle after it,
    // once the handshake has completed, and stays until the master takes it.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'b00;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= 2'b00;
        end else begin
            S_AXI_AWREADY <= wr_go & ~S_AXI_AWREADY;
            S_AXI_WREADY  <= wr_go & ~S_AXI_AWREADY;
            // The response code is captured with the address; its valid follows the handshake.
            if (wr_go && !S_AXI_AWREADY) begin
                S_AXI_BRESP  <= wr_ok ? 2'b00 : 2'b10; // Unmapped writes get SLVERR.
            end
            if (S_AXI_AWREADY) begin
                S_AXI_BVALID <= 1'b1;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            S_AXI_ARREADY <= rd_go & ~S_AXI_ARREADY;
            // Read data is captured with the address; its valid follows the handshake.
            if (rd_go && !S_AXI_ARREADY) begin
                S_AXI_RDATA  <= rd_ok ? rd_val : 32'h00000000;
                S_AXI_RRESP  <= rd_ok ? 2'b00 : 2'b10;
            end
            if (S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Trim and fuse image registers.
    // The trim value reaches the oscillator one cycle later through OSC_TRIM.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            trim  <= CAL_BYTE;
            fuses <= cst_pkg::FUSE_RESET;
        end else begin
            if (wr_trim && !S_AXI_AWREADY) begin
                trim <= S_AXI_WDATA[7:0];
            end
            if (wr_cfg && !S_AXI_AWREADY && S_AXI_WSTRB[0]) begin
                fuses <= S_AXI_WDATA[7:0];
            end
        end
    end

    // Start-up sequencer: source cycles first, then watchdog cycles.
    // A wake request from software restarts the count without the watchdog part.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            state      <= ST_CLK;
            clk_cnt    <= 16'h0000;
            wdt_cnt    <= 17'h00000;
            from_reset <= 1'b1;
        end else begin
            case (state)
                ST_CLK: begin
                    if (clk_cnt >= need.clk_cycles) begin
                        state   <= (need.wdt_cycles == cst_pkg::WDT_NONE) ? ST_RUN : ST_WDT;
                        wdt_cnt <= 17'h00000;
                    end else if (src_edge) begin
                        clk_cnt <= clk_cnt + 16'h0001;
                    end
                end
                ST_WDT: begin
                    if (wdt_cnt >= need.wdt_cycles) begin
                        state <= ST_RUN;
                    end else if (wdt_edge) begin
                        wdt_cnt <= wdt_cnt + 17'h00001;
                    end
                end
                ST_RUN: begin
                    if (wake && !S_AXI_AWREADY) begin
                        state      <= ST_CLK;
                        clk_cnt    <= 16'h0000;
                        from_reset <= 1'b0;
                    end
                end
                default: state <= ST_CLK;
            endcase
        end
    end

    // Outputs toward the core, with the divide-by-eight clock enable.
    // The divider runs freely; the enable is one pulse in eight when the fuse is programmed.
    always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
            div_cnt     <= 3'h0;
            CORE_RUN    <= 1'b0;
            CORE_CLK_EN <= 1'b0;
            OSC_TRIM    <= CAL_BYTE;
            OSC_RANGE   <= 2'b00;
            CLK_SOURCE  <= cst_pkg::SRC_RC;
        end else begin
            div_cnt     <= div_cnt + 3'h1;
            CORE_RUN    <= (state == ST_RUN);
            CORE_CLK_EN <= (state == ST_RUN) & (~div8 | (div_cnt == cst_pkg::DIV8_LAST));
            OSC_TRIM    <= trim;
            OSC_RANGE   <= sel[2:1];
            CLK_SOURCE  <= classify(sel);
        end
    end

endmodule : cst_sequencer

`default_nettype wire

// file: tb/cst_sequencer_properties.sv
// Checker for the start-up sequencer: reset state, run hold, bus handshakes.
// Assumes it is bound to cst_sequencer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module cst_sequencer_properties #(
    parameter logic [7:0] CAL_BYTE = 8'h80 // Calibration value, arbitrary default.
) (
    // Clock and reset.
    input wire logic        CORE_CLK,
    input wire logic        RSTN,
    // Write channels.
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    // Read channels.
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    // Core side.
    input wire logic        CORE_RUN,
    input wire logic        CORE_CLK_EN,
    input wire logic [7:0]  OSC_TRIM,
    input wire logic [1:0]  CLK_SOURCE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    // Leaving reset, the trim holds the calibration byte.
    property p_trim_reset; $rose(RSTN) |-> OSC_TRIM == CAL_BYTE; endproperty
    a_trim_reset: assert property (p_trim_reset) else $error("Trim not calibrated at reset");
    // Leaving reset, the core is held and the RC source is chosen.
    property p_reset_idle; $rose(RSTN) |-> !CORE_RUN && !CORE_CLK_EN && CLK_SOURCE == 2'h2; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("Core not held at reset");
    // A running core stays running while no write is near.
    property p_run_stays;
        CORE_RUN && !S_AXI_AWVALID && !S_AXI_BVALID && !$past(S_AXI_BVALID) |=> CORE_RUN;
    endproperty
    a_run_stays: assert property (p_run_stays) else $error("Core run dropped");
    // A write is taken one cycle after both valids and answered one cycle later.
    property p_wr_answer;
        S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID && !S_AXI_AWREADY |=> S_AXI_AWREADY ##1 S_AXI_BVALID;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("Write not answered");
    // A read is taken one cycle after its valid and answered one cycle later.
    property p_rd_answer; S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY |=> S_AXI_ARREADY ##1 S_AXI_RVALID; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("Read not answered");
    // The write response holds until taken.
    property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
    a_b_hold: assert property (p_b_hold) else $error("Write response dropped");
    // The read data holds until taken.
    property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("Read data dropped");
    // Address and data are taken together, and the response follows one cycle later.
    property p_aw_w_pair; S_AXI_AWREADY |-> S_AXI_WREADY ##1 S_AXI_BVALID; endproperty
    a_aw_w_pair: assert property (p_aw_w_pair) else $error("Write channels split");
endmodule : cst_sequencer_properties

bind cst_sequencer cst_sequencer_properties #(.CAL_BYTE(CAL_BYTE)) u_props (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .CORE_RUN(CORE_RUN), .CORE_CLK_EN(CORE_CLK_EN),
    .OSC_TRIM(OSC_TRIM), .CLK_SOURCE(CLK_SOURCE));
`default_nettype wire

// file: tb/test_cst_sequencer.sv
// Bench for the start-up sequencer: trim register, reset and wake delays, clock division.
// Assumes oscillator ticks are synchronised inside and the bus is AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

module test_cst_sequencer;
    logic        clk, rstn, src, wdt;            // Clock, reset, oscillator ticks.
    logic [7:0]  awaddr, araddr, trim;           // Addresses and trim output.
    logic [31:0] wdata, rdata, rd;               // Bus data and last read.
    logic [3:0]  wstrb;                          // Byte strobes.
    logic [1:0]  bresp, rresp, csrc, rng, rsp;   // Responses and source outputs.
    logic        awvalid, awready, wvalid, wready, bvalid, bready; // Write handshakes.
    logic        arvalid, arready, rvalid, rready, run, clk_en;    // Read handshakes, core side.
    int          n_mismatch = 0;                 // Mismatches seen.
    int          checked = 0;                    // Comparisons made.

    cst_sequencer #(.CAL_BYTE(8'h5A)) uut (
        .CORE_CLK(clk), .RSTN(rstn), .SRC_TICK(src), .WDT_TICK(wdt), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CORE_RUN(run), .CORE_CLK_EN(clk_en), .OSC_TRIM(trim), .OSC_RANGE(rng), .CLK_SOURCE(csrc));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (n_mismatch == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // Compares one value and reports a difference.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk

    // Bus write; each channel is released at its own ready.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, s, 2'b11};
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (awready) bready <= 1'b1;
        end while (!(bvalid && bready) && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50) begin n_mismatch++; close_out(); end
    endtask : axi_wr

    // Bus read; ready is raised once the address is taken.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk);
        {araddr, arvalid} <= {a, 1'b1};
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (arready) rready <= 1'b1;
        end while (!(rvalid && rready) && n < 50);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
        if (n >= 50) begin n_mismatch++; close_out(); end
    endtask : axi_rd

    // Gives k rising edges on the watchdog (w) or source tick.
    task automatic ticks(input logic w, input int k);
        repeat (k) begin
            @(posedge clk);
            if (w) wdt <= 1'b1; else src <= 1'b1;
            @(posedge clk);
            {wdt, src} <= 2'b00;
        end
    endtask : ticks

    // Core must stay held until the k-th tick, then run shortly after.
    task automatic count_to_run(input logic w, input int k, input string nm);
        int n;
        n = 0;
        ticks(w, k - 1);
        repeat (8) @(posedge clk);
        chk({nm, " early"}, 32'h0, {31'h0, run});
        ticks(w, 1);
        while (run !== 1'b1 && n < 20) begin @(posedge clk); n++; end
        chk(nm, 32'h1, {31'h0, run});
    endtask : count_to_run

    // Trim access, refused addresses and status while starting.
    task automatic sc_trim();
        axi_rd(cst_pkg::ADDR_TRIM, rd, rsp);
        chk("trim reset", 32'h5A, rd);
        axi_rd(cst_pkg::ADDR_CONFIG, rd, rsp);
        chk("config reset", {24'h0, cst_pkg::FUSE_RESET}, rd);
        axi_wr(cst_pkg::ADDR_TRIM, 32'hA5, 4'h1, rsp);
        axi_rd(cst_pkg::ADDR_TRIM, rd, rsp);
        chk("trim read", 32'hA5, rd);
        chk("trim out", 32'hA5, {24'h0, trim});
        axi_wr(cst_pkg::ADDR_TRIM, 32'h3C, 4'hE, rsp);
        axi_rd(cst_pkg::ADDR_TRIM, rd, rsp);
        chk("trim strobe", 32'hA5, rd);
        axi_wr(8'h0C, 32'h1, 4'hF, rsp);
        chk("bad wr resp", 32'h2, {30'h0, rsp});
        axi_rd(8'h0C, rd, rsp);
        chk("bad rd", 32'h2, {30'h0, rsp} | rd);
        axi_rd(cst_pkg::ADDR_STATUS, rd, rsp);
        chk("status", 32'h6, {28'h0, rd[3:0]});
    endtask : sc_trim

    // Reset start-up with SUT 01 written first: 14 source ticks, then 4096 watchdog ticks.
    task automatic sc_start();
        axi_wr(cst_pkg::ADDR_CONFIG, 32'h92, 4'h1, rsp);
        axi_rd(cst_pkg::ADDR_CONFIG, rd, rsp);
        chk("config write", 32'h92, rd);
        ticks(1'b0, 14);
        repeat (4) @(posedge clk);
        count_to_run(1'b1, 4096, "reset run");
        chk("source", 32'h2, {30'h0, csrc});
    endtask : sc_start

    // Counts core enables over 16 cycles.
    task automatic sc_div(input logic [31:0] e);
        int k;
        k = 0;
        repeat (16) begin @(posedge clk); if (clk_en === 1'b1) k++; end
        chk("clk_en rate", e, k);
    endtask : sc_div

    // Wake from RC, crystal and fast low-frequency sources, covering each crystal wake delay.
    task automatic sc_wake();
        logic [7:0] cfg [8] = '{8'hC2, 8'hD8, 8'hC9, 8'hCB, 8'hEC, 8'hFE, 8'hD9, 8'hC6};
        int         n [8]   = '{6, 258, 1024, 1024, 1024, 1024, 16384, 1024};
        logic [1:0] s [8]   = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1};
        for (int i = 0; i < 8; i++) begin
            axi_wr(cst_pkg::ADDR_CONFIG, {23'h0, 1'b1, cfg[i]}, 4'hF, rsp);
            count_to_run(1'b0, n[i], "wake run");
            chk("source", {30'h0, s[i]}, {30'h0, csrc});
            if (s[i] == 2'h0) chk("range", {30'h0, cfg[i][2:1]}, {30'h0, rng});
        end
    endtask : sc_wake

    // A second reset reloads the calibration byte and holds the core.
    task automatic sc_rereset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk("trim rereset", 32'h5A, {24'h0, trim});
        chk("run rereset", 32'h0, {31'h0, run});
        axi_wr(cst_pkg::ADDR_CONFIG, 32'h42, 4'h1, rsp);
        ticks(1'b0, 14);
        repeat (4) @(posedge clk);
        count_to_run(1'b1, 4096, "pin disable run");
    endtask : sc_rereset

    // Main sequence.
    initial begin
        {rstn, src, wdt, awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        sc_trim();
        sc_start();
        sc_div(32'd2);
        sc_wake();
        sc_div(32'd16);
        sc_rereset();
        close_out();
    end

    // Cuts a hang short.
    initial begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule : test_cst_sequencer
`default_nettype wire
